// ### logic/decode_pkg.sv
// Constants for the decode slot steering stage.
// Assumes a single core clock and a synchronous active-low core reset.
//
// Contract
// - Complex instructions go to microcode flow ROM
// - Bad predecode: one instruction per three cycles
// - Two-wide: 16 bytes, long instruction alone slot0
// - Three-wide: 20 bytes when group starts aligned
// - Three-wide: long instruction not slot0 restricted
// - Prefix over limit adds three cycle penalty
// - Prefix limit three bytes, or four bytes
// - Only slot zero decodes over-limit prefix instruction
// - Branches per cycle: one, or two
// - Two floating stack instructions decode together freely
// - Two-wide: branch in slot one costs three; code charges it only when slot zero also holds a branch
// - Three-wide: two not-taken branches slot0/1 cost three
// - Taken or unconditional branch adds one bubble
// - Over-limit prefix off slot zero costs six; code charges it only when nothing issues ahead of it
// - Microcode entry on slot one costs three extra
package decode_pkg;
  // ==========================================================
  // Geometry
  localparam int MAX_SLOTS = 3;
  localparam int LEN_W = 5;
  localparam int PFX_W = 4;
  localparam int BYTES_W = 6;
  localparam int CNT_W = 3;
  // ==========================================================
  // Variant limits
  localparam logic [BYTES_W-1:0] BYTES_A = 6'h10;
  localparam logic [BYTES_W-1:0] BYTES_B = 6'h14;
  localparam logic [LEN_W-1:0] LONG_LEN = 5'h08;
  localparam logic [PFX_W-1:0] PFX_LIM_A = 4'h3;
  localparam logic [PFX_W-1:0] PFX_LIM_B = 4'h4;
  localparam logic [1:0] BR_LIM_A = 2'h1;
  localparam logic [1:0] BR_LIM_B = 2'h2;
  localparam logic [1:0] ALIGN_MASK = 2'h3;
  // ==========================================================
  // Penalty counts, in cycles
  localparam logic [CNT_W-1:0] PEN_PFX = 3'h3;
  localparam logic [CNT_W-1:0] PEN_RESTEER_PFX = 3'h6;
  localparam logic [CNT_W-1:0] PEN_BRANCH = 3'h3;
  localparam logic [CNT_W-1:0] PEN_UCODE = 3'h3;
  localparam logic [CNT_W-1:0] PEN_TAKEN = 3'h1;
  localparam logic [CNT_W-1:0] PREDECODE_GAP = 3'h3;
  // ==========================================================
  // Instruction kind
  typedef enum logic [2:0] {
    K_SIMPLE = 3'h1,
    K_BRANCH = 3'h2,
    K_UCODE = 3'h4
  } kind_e;
endpackage

// ### logic/slot_classify.sv
// One slot's classification of an offered instruction.
// Assumes inputs are registered in the core clock domain.
`timescale 1ns/100ps
module slot_classify #(
  parameter logic [3:0] PFX_LIM = decode_pkg::PFX_LIM_A
) (
  // Instruction
  input wire logic [decode_pkg::LEN_W-1:0] i_len,
  input wire logic [decode_pkg::PFX_W-1:0] i_pfx,
  input wire logic [2:0] i_kind,
  input wire logic i_pred_taken,
  input wire logic i_uncond,
  // Result
  output logic o_long,
  output logic o_pfx_over,
  output logic o_branch,
  output logic o_ucode,
  output logic o_redirect
);
  always_comb begin
    o_long = i_len > decode_pkg::LONG_LEN;
    o_pfx_over = i_pfx > PFX_LIM;
    o_branch = i_kind == decode_pkg::K_BRANCH;
    o_ucode = i_kind == decode_pkg::K_UCODE;
    o_redirect = o_branch && (i_pred_taken || i_uncond);
  end
endmodule

// ### logic/decode_slot_steering.sv
// Decode slot steering: takes a window of up to three fetched
// instructions and issues an in-order group onto decoder slots.
// Assumes fetch holds its offer steady while o_fetch_ready is low.
`timescale 1ns/100ps
module decode_slot_steering #(
  parameter bit WIDE = 1'b0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Fetch offer, oldest instruction at index 0
  input wire logic [2:0] i_valid,
  input wire logic [3*decode_pkg::LEN_W-1:0] i_len,
  input wire logic [3*decode_pkg::PFX_W-1:0] i_pfx,
  input wire logic [8:0] i_kind,
  input wire logic [2:0] i_pred_taken,
  input wire logic [2:0] i_uncond,
  input wire logic i_predecode_bad,
  input wire logic [1:0] i_start_align,
  output logic o_fetch_ready,
  // Decoded group to allocation
  output logic [2:0] o_slot_valid,
  output logic [2:0] o_slot_ucode,
  output logic [1:0] o_taken_count
);
  localparam int S = decode_pkg::MAX_SLOTS;
  localparam int CW = decode_pkg::CNT_W;
  localparam int NS = WIDE ? 3 : 2;
  localparam logic [3:0] PLIM = WIDE ? decode_pkg::PFX_LIM_B : decode_pkg::PFX_LIM_A;
  localparam logic [5:0] BLIM = WIDE ? decode_pkg::BYTES_B : decode_pkg::BYTES_A;
  localparam logic [5:0] BLIM_UNAL = decode_pkg::BYTES_A;
  localparam logic [1:0] BRLIM = WIDE ? decode_pkg::BR_LIM_B : decode_pkg::BR_LIM_A;

  // ==========================================================
  // Input synchronisation is not needed: fetch shares the clock
  logic [S-1:0] lng, pov, br, uc, rd;
  genvar g;
  generate
    for (g = 0; g < S; g++) begin : g_cls
      slot_classify #(.PFX_LIM(PLIM)) u_cls (
        .i_len(i_len[g*decode_pkg::LEN_W +: decode_pkg::LEN_W]),
        .i_pfx(i_pfx[g*decode_pkg::PFX_W +: decode_pkg::PFX_W]),
        .i_kind(i_kind[g*3 +: 3]),
        .i_pred_taken(i_pred_taken[g]),
        .i_uncond(i_uncond[g]),
        .o_long(lng[g]),
        .o_pfx_over(pov[g]),
        .o_branch(br[g]),
        .o_ucode(uc[g]),
        .o_redirect(rd[g])
      );
    end
  endgenerate

  // ==========================================================
  // Group selection
  logic [CW-1:0] pen_q, pen_d;
  logic [2:0] grp;
  logic [CW-1:0] pen_new;
  logic [5:0] bytes;
  logic [5:0] blim_eff;
  logic [1:0] nbr;
  logic stop;
  logic [1:0] ntaken;
  always_comb begin
    grp = 3'h0;
    pen_new = '0;
    bytes = '0;
    nbr = '0;
    ntaken = '0;
    stop = 1'b0;
    // Peak width only when the group's first instruction is aligned
    blim_eff = (WIDE && ((i_start_align & decode_pkg::ALIGN_MASK) == 2'h0)) ? BLIM : BLIM_UNAL;
    for (int k = 0; k < S; k++) begin
      if (!stop && k < NS && i_valid[k]) begin
        // Program order: an invalid entry is skipped and does not end the group
        if (k > 0 && pov[k]) begin
          // Over-limit prefix must restart on slot 0
          stop = 1'b1;
          if (grp == 3'h0) pen_new = decode_pkg::PEN_RESTEER_PFX;
        end else if (k > 0 && uc[k]) begin
          stop = 1'b1;
          if (k == 1) pen_new = decode_pkg::PEN_UCODE;
        end else if (!WIDE && lng[k] && k > 0) begin
          stop = 1'b1;
        end else if (6'(bytes + 6'(i_len[k*decode_pkg::LEN_W +: decode_pkg::LEN_W])) > blim_eff) begin
          stop = 1'b1;
        end else if (br[k] && nbr >= BRLIM) begin
          stop = 1'b1;
          pen_new = decode_pkg::PEN_BRANCH;
        end else if (WIDE && k == 1 && br[0] && br[1] && !rd[0]) begin
          // Branch in slot 1 after a not-taken branch in slot 0
          grp[k] = 1'b1;
          stop = 1'b1;
          pen_new = decode_pkg::PEN_BRANCH;
        end else begin
          // Floating stack pairs need no special case here
          grp[k] = 1'b1;
          bytes = 6'(bytes + 6'(i_len[k*decode_pkg::LEN_W +: decode_pkg::LEN_W]));
          if (br[k]) nbr = 2'(nbr + 2'h1);
          if (pov[k]) pen_new = decode_pkg::PEN_PFX;
          if (uc[k]) stop = 1'b1;
          if (!WIDE && lng[k]) stop = 1'b1;
          if (rd[k]) begin
            stop = 1'b1;
            ntaken = 2'(ntaken + 2'h1);
            if (pen_new < decode_pkg::PEN_TAKEN) pen_new = decode_pkg::PEN_TAKEN;
          end
        end
      end
    end
    if (i_predecode_bad && grp != 3'h0) begin
      grp = 3'h1;
      ntaken = {1'b0, rd[0]};
      pen_new = 3'(decode_pkg::PREDECODE_GAP - 3'h1);
    end
  end
  // in the wide variant, long instructions take no special path above

  // ==========================================================
  // Penalty counter and issue registers
  logic [2:0] sv_q, sv_d, su_q, su_d;
  logic [1:0] tc_q, tc_d;
  logic rdy_q, rdy_d;
  logic busy;
  always_comb begin
    busy = pen_q != '0;
    pen_d = busy ? 3'(pen_q - 3'h1) : pen_new;
    sv_d = busy ? 3'h0 : grp;
    su_d = busy ? 3'h0 : (grp & uc);
    tc_d = busy ? 2'h0 : ntaken;
    // Stall fetch while penalty cycles remain
    rdy_d = (pen_d == '0);
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pen_q <= '0;
      sv_q <= '0;
      su_q <= '0;
      tc_q <= '0;
      rdy_q <= 1'b1;
    end else begin
      pen_q <= pen_d;
      sv_q <= sv_d;
      su_q <= su_d;
      tc_q <= tc_d;
      rdy_q <= rdy_d;
    end
  end
  // Group is taken when ready was high; fetch must then advance by the count
  always_comb begin
    o_fetch_ready = rdy_q;
    o_slot_valid = sv_q;
    o_slot_ucode = su_q;
    o_taken_count = tc_q;
  end

  // ==========================================================
  // Checks
  a_pfx_slot_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (rdy_q && i_valid[1] && pov[1]) |=> !o_slot_valid[1]) else $error("prefix over slot1");
  a_ucode_alone: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (rdy_q && !busy && i_valid[0] && uc[0]) |=> o_slot_valid == 3'h1) else $error("ucode group");
  a_predecode_rate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (rdy_q && i_predecode_bad && i_valid[0]) |=> o_slot_valid == 3'h1 ##1 !o_slot_valid[0] [*2])
    else $error("predecode rate");
  a_pfx_penalty: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (rdy_q && !i_predecode_bad && i_valid[0] && pov[0]) |=> !o_fetch_ready [*3])
    else $error("prefix penalty");
  a_resteer_six: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (rdy_q && !i_predecode_bad && !i_valid[0] && i_valid[1] && pov[1])
    |=> !o_fetch_ready [*6]) else $error("resteer penalty");
  a_taken_bubble: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_taken_count != 2'h0) |-> !o_fetch_ready) else $error("taken bubble");
  a_stall_penalty: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (pen_q != '0) |-> !o_fetch_ready ##1 o_slot_valid == 3'h0) else $error("stall");
  a_slot_order: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_slot_valid[1] |-> o_slot_valid[0]) and (o_slot_valid[2] |-> o_slot_valid[1])) else $error("order");
endmodule

// ### bench/fetch_model.sv
// Fetch-side partner: holds one offered window until decode takes it.
// Assumes the bench loads a window only while o_busy is low.
`timescale 1ns/100ps
module fetch_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Bench side
  input wire logic i_load,
  input wire logic [47:0] i_word,
  output logic o_busy,
  // Decode side
  input wire logic i_fetch_ready,
  output logic [47:0] o_offer
);
  logic [47:0] hold_q;
  // ==========================================================
  // Offer stays put until a ready edge takes it
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_busy <= 1'b0;
      hold_q <= 48'h0;
    end else if (i_load) begin
      o_busy <= 1'b1;
      hold_q <= i_word;
    end else if (i_fetch_ready) begin
      o_busy <= 1'b0;
    end
  end
  // Released lines show the inverse and valid bits zero so a stale window never looks live
  assign o_offer = o_busy ? hold_q : {~hold_q[47:3], 3'h0};
endmodule

// ### bench/decode_slot_steering_tb.sv
// Self-checking bench for the two-wide decode steering stage.
// Assumes the fetch partner model and the design package are compiled first.
`timescale 1ns/100ps
module decode_slot_steering_tb;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic load = 1'b0;
  logic [47:0] word = 48'h0;
  logic busy;
  logic [47:0] offer;
  logic ready;
  logic [2:0] slot_valid;
  logic [2:0] slot_ucode;
  logic [1:0] taken_count;
  logic [7:0] expq[$];
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] rnd = 32'hCB25;
  always #50 i_clk = ~i_clk;
  fetch_model fetch_model_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_load(load), .i_word(word),
    .o_busy(busy), .i_fetch_ready(ready), .o_offer(offer));
  decode_slot_steering #(.WIDE(1'b0)) decode_slot_steering_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_valid(offer[2:0]), .i_len(offer[17:3]), .i_pfx(offer[29:18]), .i_kind(offer[38:30]),
    .i_pred_taken(offer[41:39]), .i_uncond(offer[44:42]), .i_predecode_bad(offer[45]),
    .i_start_align(offer[47:46]), .o_fetch_ready(ready), .o_slot_valid(slot_valid),
    .o_slot_ucode(slot_ucode), .o_taken_count(taken_count));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic bad(input string msg);
    miscompares++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One window; exp is {taken count, ucode mask, slot mask}; gap below zero skips the stall check
  task automatic run(input string name, input logic [2:0] v, input logic [14:0] l, input logic [11:0] p,
      input logic [8:0] k, input logic [2:0] t, input logic f, input logic [7:0] exp, input int gap);
    int n;
    n = 0;
    // A window that issues nothing carries an all-zero note and queues none
    if (exp != 8'h00) expq.push_back(exp);
    @(posedge i_clk);
    #1;
    rnd = lfsr(rnd);
    word = {rnd[1:0], f, 3'h0, t, k, p, l, v};
    load = 1'b1;
    @(posedge i_clk);
    #1;
    load = 1'b0;
    while (busy === 1'b1 && n < 50) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (gap >= 0) begin
      samples_checked++;
      if (n != gap) bad($sformatf("%s stall %0d", name, n));
    end
    repeat (3) @(posedge i_clk);
    $display("test %s done", name);
  endtask
  // ==========================================================
  // Result watcher: a group is a one-cycle pulse, so sample mid-cycle
  always @(negedge i_clk) begin
    if (i_reset_n === 1'b1 && slot_valid !== 3'h0) begin
      samples_checked++;
      if (expq.size() == 0) begin
        bad("unexpected group");
      end else if ({taken_count, slot_ucode, slot_valid} !== expq.pop_front()) begin
        bad("group contents");
      end
    end
  end
  // Whole run is well under a thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad("timeout");
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    run("pair", 3'h3, 15'h0084, 12'h000, 9'h009, 3'h0, 1'b0, 8'h03, 0);
    run("pfx_at_limit", 3'h3, 15'h0084, 12'h033, 9'h009, 3'h0, 1'b0, 8'h03, 0);
    run("pfx_over", 3'h3, 15'h0084, 12'h004, 9'h009, 3'h0, 1'b0, 8'h03, 3);
    run("resteer", 3'h2, 15'h0084, 12'h040, 9'h009, 3'h0, 1'b0, 8'h00, 6);
    run("long", 3'h3, 15'h0049, 12'h000, 9'h009, 3'h0, 1'b0, 8'h01, -1);
    run("ucode0", 3'h3, 15'h0084, 12'h000, 9'h00C, 3'h0, 1'b0, 8'h09, -1);
    run("ucode1", 3'h3, 15'h0084, 12'h000, 9'h021, 3'h0, 1'b0, 8'h01, 3);
    run("branch_pair", 3'h3, 15'h0084, 12'h000, 9'h012, 3'h0, 1'b0, 8'h01, 3);
    run("taken", 3'h1, 15'h0004, 12'h000, 9'h002, 3'h1, 1'b0, 8'h41, 1);
    run("predecode", 3'h3, 15'h0084, 12'h000, 9'h009, 3'h0, 1'b1, 8'h01, 2);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      run("random", 3'h3, {7'h0, rnd[6:4] | 3'h1, 2'h0, rnd[9:7] | 3'h1}, 12'h000, 9'h009, 3'h0, 1'b0,
        8'h03, 0);
    end
    repeat (4) @(posedge i_clk);
    if (expq.size() != 0) bad("group missing");
    tally_and_finish();
  end
endmodule
